// File: include/vss_pkg.sv
// Shared types and constants for the video selector switch control
// Behaviour
// - Serial mode with the select pin low answers to a bus address whose lowest bit is 1.
// - Serial mode with the select pin high answers to a bus address whose lowest bit is 0.
// - Direct mode decodes select, data and clock pins as static inputs into switch patterns.
// - The serial slave copes with bus clock rates up to 100 kHz, and the bench master runs far above it.
// - The device pulls the data line low in the acknowledge slot of a byte addressed to it.
// - Data bits 0 to 4 turn pair 0, pair 1, pair 2, set 1 and set 2 on when 1 and off when 0.
// - Only writes are accepted, so the address matches only with the read/write bit at 0.
// - Every complete data byte after a good address updates the switches until STOP or START.
// - After power-up serial mode has every switch off, and direct mode follows the pins four system clocks later.
package vss_pkg;
   localparam int CLK_MHZ = 125;
   localparam int SCL_MAX_KHZ = 100;
   // Shortest legal bus clock period in system clocks
   localparam int SCL_MIN_PERIOD_CYC = (CLK_MHZ * 1000) / SCL_MAX_KHZ;
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] BIT_CNT_RST = 4'h0;
   localparam logic [3:0] BIT_CNT_FULL = 4'h8;
   localparam logic [7:0] SHREG_RST = 8'h00;
   localparam logic [1:0] ADDR_FIXED_BIT = 2'h0;

   typedef struct packed {
      logic set2;
      logic set1;
      logic pair2;
      logic pair1;
      logic pair0;
   } vss_switch_t;

   localparam vss_switch_t SW_OFF = 5'h00;

   typedef struct packed {
      logic mode;
      logic sel;
      logic sda;
      logic scl;
   } vss_pins_t;

   typedef struct packed {
      vss_pins_t lvl;
      logic scl_rise;
      logic scl_fall;
      logic sda_rise;
      logic sda_fall;
   } vss_sampled_t;

   // Gray along idle -> addr -> ack -> data
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ACK = 3'h3,
      ST_DATA = 3'h2,
      ST_IGNORE = 3'h6
   } vss_state_t;

   // Direct-mode truth table
   function automatic vss_switch_t vss_decode(input logic sel, input logic sda, input logic scl);
      vss_switch_t s;
      s = SW_OFF;
      case ({sel, sda, scl})
         3'h1: s.pair0 = 1'b1;
         3'h2: s.pair1 = 1'b1;
         3'h3: s.pair2 = 1'b1;
         3'h4: s.set1 = 1'b1;
         3'h5: s.set2 = 1'b1;
         3'h6: begin
            s.set1 = 1'b1;
            s.pair1 = 1'b1;
         end
         3'h7: begin
            s.set2 = 1'b1;
            s.pair2 = 1'b1;
         end
         default: s = SW_OFF;
      endcase
      return s;
   endfunction
endpackage

// File: rtl/vss_sync.sv
// Pin synchroniser with edge detection for the bus lines
`timescale 1ns/1ns
`default_nettype none
module vss_sync (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire vss_pkg::vss_pins_t pins,
   output vss_pkg::vss_sampled_t smp
);
   import vss_pkg::*;

   typedef struct packed {
      vss_pins_t s1;
      vss_pins_t s2;
      vss_pins_t s3;
      vss_sampled_t out;
   } vss_sync_st_t;

   vss_sync_st_t q, d;

   // Edges come from stages two and three, never from the first stage
   always_comb begin
      d = q;
      d.s1 = pins;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.out.lvl = q.s2;
      d.out.scl_rise = q.s2.scl & ~q.s3.scl;
      d.out.scl_fall = ~q.s2.scl & q.s3.scl;
      d.out.sda_rise = q.s2.sda & ~q.s3.sda;
      d.out.sda_fall = ~q.s2.sda & q.s3.sda;
   end

   // Bus lines reset high so no false edge follows reset; mode resets to serial
   // so a stale direct pattern never reaches the switches while the stages refill
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         q <= {4'h7, 4'h7, 4'h7, 4'h7, 4'h0};
      end else begin
         q <= d;
      end
   end

   assign smp = q.out;
endmodule
`default_nettype wire

// File: rtl/vss_top.sv
// Switch control for the component video selector: two-wire slave and direct decode
`timescale 1ns/1ns
`default_nettype none
module vss_top #(
   parameter logic [4:0] ADDR_HI = 5'h00 // Upper address bits, arbitrary value
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic serial_mode_low,
   input wire logic group_or_address_select,
   input wire logic sda_i,
   input wire logic scl_i,
   output logic sda_o,
   output logic sda_oe,
   output vss_pkg::vss_switch_t sw
);
   import vss_pkg::*;

   // Slow bus is heavily oversampled, so 100 kHz leaves wide margin
   if (SCL_MIN_PERIOD_CYC < 8) begin : g_rate_chk
      $error("System clock too slow for the serial bus");
   end

   typedef struct packed {
      vss_state_t st;
      logic [3:0] cnt;
      logic [7:0] shreg;
      vss_switch_t sw;
      logic oe;
      logic sdo;
   } vss_top_st_t;

   vss_sampled_t smp;
   vss_pins_t raw;
   vss_top_st_t q, d;
   logic start_c;
   logic stop_c;
   logic byte_done;
   logic addr_ok;

   assign raw = '{mode: serial_mode_low, sel: group_or_address_select, sda: sda_i, scl: scl_i};

   vss_sync u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pins(raw),
      .smp(smp)
   );

   // Bus conditions and address compare
   always_comb begin
      start_c = smp.sda_fall & smp.lvl.scl;
      stop_c = smp.sda_rise & smp.lvl.scl;
      byte_done = smp.scl_fall && (q.cnt == BIT_CNT_FULL);
      // Low address bit is the inverse of select; write only
      addr_ok = (q.shreg[7:1] == {ADDR_HI, ADDR_FIXED_BIT[0], ~smp.lvl.sel})
         && !q.shreg[0];
   end

   // Protocol and switch state
   always_comb begin
      d = q;
      d.sdo = 1'b0;
      if (smp.lvl.mode) begin
         // Direct mode: pins decoded every cycle, slave kept idle
         d.sw = vss_decode(smp.lvl.sel, smp.lvl.sda, smp.lvl.scl);
         d.st = ST_IDLE;
         d.oe = 1'b0;
         d.cnt = BIT_CNT_RST;
      end else if (start_c) begin
         d.st = ST_ADDR;
         d.cnt = BIT_CNT_RST;
         d.oe = 1'b0;
      end else if (stop_c) begin
         d.st = ST_IDLE;
         d.oe = 1'b0;
      end else begin
         case (q.st)
            ST_ADDR, ST_DATA: begin
               if (smp.scl_rise && q.cnt != BIT_CNT_FULL) begin
                  // MSB first
                  d.shreg = {q.shreg[6:0], smp.lvl.sda};
                  d.cnt = q.cnt + 4'h1;
               end else if (byte_done) begin
                  d.cnt = BIT_CNT_RST;
                  if (q.st == ST_DATA) begin
                     d.sw = q.shreg[4:0];
                     d.st = ST_ACK;
                     d.oe = 1'b1;
                  end else if (addr_ok) begin
                     d.st = ST_ACK;
                     d.oe = 1'b1;
                  end else begin
                     d.st = ST_IGNORE;
                  end
               end
            end
            ST_ACK: begin
               // Release after the ninth clock so the master owns the line again
               if (smp.scl_fall) begin
                  d.oe = 1'b0;
                  d.st = ST_DATA;
               end
            end
            ST_IGNORE: d.st = ST_IGNORE;
            ST_IDLE: d.st = ST_IDLE;
            default: d.st = ST_IDLE;
         endcase
      end
   end

   // Power-up leaves every switch off
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         q <= '{st: ST_IDLE, cnt: BIT_CNT_RST, shreg: SHREG_RST, sw: SW_OFF,
                oe: 1'b0, sdo: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign sw = q.sw;
   assign sda_oe = q.oe;
   assign sda_o = q.sdo;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   property p_addr_sel_low;
      (q.st == ST_ADDR && byte_done && !smp.lvl.mode && !start_c && !stop_c && !smp.lvl.sel
         && q.shreg == {ADDR_HI, 3'h2}) |=> (q.st == ST_ACK && q.oe);
   endproperty
   a_addr_sel_low: assert property (p_addr_sel_low) else $error("Missed address 1");

   property p_addr_sel_high;
      (q.st == ST_ADDR && byte_done && !smp.lvl.mode && !start_c && !stop_c && smp.lvl.sel
         && q.shreg[1]) |=> (q.st == ST_IGNORE && !q.oe);
   endproperty
   a_addr_sel_high: assert property (p_addr_sel_high) else $error("Acked wrong address");

   property p_direct;
      smp.lvl.mode |=> q.sw == vss_decode($past(smp.lvl.sel), $past(smp.lvl.sda),
                                          $past(smp.lvl.scl));
   endproperty
   a_direct: assert property (p_direct) else $error("Direct decode mismatch");

   property p_ack_slot;
      (q.st == ST_ACK && !smp.lvl.mode) |-> (q.oe && !q.sdo);
   endproperty
   a_ack_slot: assert property (p_ack_slot) else $error("Data line not low in ack slot");

   property p_data_apply;
      (q.st == ST_DATA && byte_done && !smp.lvl.mode && !start_c && !stop_c)
         |=> (q.sw == $past(q.shreg[4:0])) ##1 $stable(q.sw);
   endproperty
   a_data_apply: assert property (p_data_apply) else $error("Data byte not applied");

   property p_read_refused;
      (q.st == ST_ADDR && byte_done && !smp.lvl.mode && !start_c && !stop_c && q.shreg[0])
         |=> !q.oe [*2];
   endproperty
   a_read_refused: assert property (p_read_refused) else $error("Read was acknowledged");

   property p_stop_holds;
      (stop_c && !smp.lvl.mode) |=> ($stable(q.sw) && q.st == ST_IDLE);
   endproperty
   a_stop_holds: assert property (p_stop_holds) else $error("Stop disturbed switches");

   // Own disable clause, the default one would mask exactly the reset cycles
   property p_reset_off;
      @(posedge sys_clk) disable iff (1'b0) !rstn |=> (q.sw == SW_OFF && !q.oe);
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("Switches on after reset");

   property p_shift_msb;
      (q.st == ST_DATA && smp.scl_rise && q.cnt != BIT_CNT_FULL && !smp.lvl.mode && !start_c
         && !stop_c) |=> (q.shreg[0] == $past(smp.lvl.sda) && q.cnt == $past(q.cnt) + 4'h1);
   endproperty
   a_shift_msb: assert property (p_shift_msb) else $error("Bit not shifted in");

   // Only the acknowledge slot may pull the data line
   property p_oe_only_ack;
      q.oe |-> (q.st == ST_ACK);
   endproperty
   a_oe_only_ack: assert property (p_oe_only_ack) else $error("Data line driven outside ack");

   property p_ack_release;
      (q.st == ST_ACK && smp.scl_fall && !smp.lvl.mode && !start_c && !stop_c)
         |=> (q.st == ST_DATA && !q.oe);
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("Ack not released");

   property p_sel_hi_hit;
      (q.st == ST_ADDR && byte_done && !smp.lvl.mode && !start_c && !stop_c && smp.lvl.sel
         && q.shreg == {ADDR_HI, 3'h0}) |=> (q.st == ST_ACK && q.oe);
   endproperty
   a_sel_hi_hit: assert property (p_sel_hi_hit) else $error("Missed address 0");

   property p_sel_lo_miss;
      (q.st == ST_ADDR && byte_done && !smp.lvl.mode && !start_c && !stop_c && !smp.lvl.sel
         && !q.shreg[1]) |=> (q.st == ST_IGNORE && !q.oe);
   endproperty
   a_sel_lo_miss: assert property (p_sel_lo_miss) else $error("Acked address 0");

   // Counter never runs past one byte, so no ninth bit is shifted in
   property p_cnt_bound;
      q.cnt <= BIT_CNT_FULL;
   endproperty
   a_cnt_bound: assert property (p_cnt_bound) else $error("Bit count overrun");

   property p_start_restart;
      (start_c && !smp.lvl.mode)
         |=> (q.st == ST_ADDR && q.cnt == BIT_CNT_RST && !q.oe && $stable(q.sw));
   endproperty
   a_start_restart: assert property (p_start_restart) else $error("Start not handled");

   // Switches stay put while the slave is not addressed
   property p_quiet_sw;
      ((q.st == ST_IDLE || q.st == ST_IGNORE) && !smp.lvl.mode) |=> $stable(q.sw);
   endproperty
   a_quiet_sw: assert property (p_quiet_sw) else $error("Switches moved unaddressed");

   c_ack: cover property (q.st == ST_ACK ##1 q.st == ST_DATA);
   c_ignore: cover property (q.st == ST_IGNORE);
   c_apply: cover property (q.st == ST_DATA && byte_done);
   c_direct: cover property (smp.lvl.mode && q.sw.set2 && q.sw.pair2);
   c_abort: cover property (stop_c && q.st == ST_DATA && q.cnt != BIT_CNT_RST);
endmodule
`default_nettype wire

// File: testbench/vss_master.sv
// Two-wire bus master model for the selector's serial lines
`timescale 1ns/1ns
`default_nettype none
module vss_master (
   input wire logic sys_clk,
   input wire logic sda_line,
   output var logic scl = 1'b1,
   output var logic sda_pull = 1'b0
);
   task automatic hold(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // One 160 ns pulse, far above the rated ceiling to keep runs short
   task automatic pulse(input logic b, output logic seen);
      sda_pull <= ~b;
      hold(5);
      scl <= 1'b1;
      hold(5);
      seen = sda_line;
      hold(5);
      scl <= 1'b0;
      hold(5);
   endtask
   // Also a repeated start when the clock is low on entry
   task automatic start();
      sda_pull <= 1'b0;
      hold(5);
      scl <= 1'b1;
      hold(5);
      sda_pull <= 1'b1; // Data falls, clock high
      hold(5);
      scl <= 1'b0;
      hold(5);
   endtask
   task automatic stop();
      sda_pull <= 1'b1;
      hold(5);
      scl <= 1'b1;
      hold(5);
      sda_pull <= 1'b0; // Data rises, clock high
      hold(5);
   endtask
   // MSB first; ninth pulse leaves data released for the ack
   task automatic send(input logic [7:0] b, input int nbits, output logic ack);
      logic s;
      for (int i = 7; i > 7 - nbits; i--) pulse(b[i], s);
      if (nbits == 8) pulse(1'b1, ack);
   endtask
endmodule
`default_nettype wire

// File: testbench/tb_video_selector_switch_control.sv
// Self-checking bench for the selector switch control
`timescale 1ns/1ns
`default_nettype none
module tb_video_selector_switch_control;
   import vss_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic mode = 1'b1;
   logic sel = 1'b0;
   logic d_sda = 1'b0;
   logic d_scl = 1'b0;
   logic m_scl, m_pull, sda_o, sda_oe, ack, sda_line;
   logic [7:0] r;
   vss_switch_t sw, sw_prev, last;
   vss_switch_t exp_q[$];
   vss_switch_t tbl [8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h0A, 5'h14};
   int num_errors = 0;
   int checks_done = 0;

   always #4 sys_clk = ~sys_clk;
   // Wired line with pull-up
   assign sda_line = ~(m_pull | (sda_oe & ~sda_o));

   vss_master m (.sys_clk(sys_clk), .sda_line(sda_line), .scl(m_scl), .sda_pull(m_pull));
   vss_top dut (.sys_clk(sys_clk), .rstn(rstn), .serial_mode_low(mode),
      .group_or_address_select(sel), .sda_i(mode ? d_sda : sda_line),
      .scl_i(mode ? d_scl : m_scl), .sda_o(sda_o), .sda_oe(sda_oe), .sw(sw));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Only real changes are noted, the watcher sees edges of sw
   task automatic expect_sw(input vss_switch_t v);
      if (v !== last) exp_q.push_back(v);
      last = v;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
      m.start();
      m.send(a, 8, ack);
      check("addr ack", {7'h00, ack}, {7'h00, ~ok});
      if (ok) expect_sw(d[4:0]);
      m.send(d, 8, ack);
      check("data ack", {7'h00, ack}, {7'h00, ~ok});
      m.stop();
   endtask

   // Each change of sw is matched against the oldest note
   always @(posedge sys_clk) begin
      sw_prev <= sw;
      if (rstn && sw !== sw_prev) begin
         if (exp_q.size() == 0) check("sw extra", {3'h0, sw}, {3'h0, sw_prev});
         else check("sw", {3'h0, sw}, {3'h0, exp_q.pop_front()});
      end
   end

   // A hang costs far more than the 50 us the tests need
   initial begin
      #200000;
      num_errors++;
      give_verdict();
   end

   initial begin
      void'($urandom(46463));
      last = SW_OFF;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (6) @(posedge sys_clk);
      for (int i = 1; i < 24; i++) begin
         r = (i < 8) ? 8'(i) : 8'($urandom);
         if (i == 8) r = 8'h00;
         sel <= r[2];
         d_sda <= r[1];
         d_scl <= r[0];
         expect_sw(tbl[r[2:0]]);
         repeat (8) @(posedge sys_clk);
      end
      $display("direct decode done");
      rstn <= 1'b0;
      mode <= 1'b0;
      sel <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      last = SW_OFF;
      repeat (8) @(posedge sys_clk);
      check("power-up sw", {3'h0, sw}, 8'h00);
      for (int k = 0; k < 6; k++) wr(8'h02, 8'($urandom), 1'b1);
      wr(8'h00, 8'h1F, 1'b0);
      wr(8'h03, 8'h1F, 1'b0);
      sel <= 1'b1;
      repeat (8) @(posedge sys_clk);
      wr(8'h00, 8'h15, 1'b1);
      wr(8'h02, 8'h0A, 1'b0);
      wr(8'h80, 8'h0A, 1'b0);
      $display("address match done");
      // Stream, partial byte, repeated start, partial byte again
      m.start();
      m.send(8'h00, 8, ack);
      expect_sw(5'h03);
      m.send(8'h03, 8, ack);
      expect_sw(5'h1C);
      m.send(8'hFC, 8, ack);
      m.send(8'h11, 4, ack);
      m.start();
      m.send(8'h00, 8, ack);
      check("restart ack", {7'h00, ack}, 8'h00);
      expect_sw(5'h05);
      m.send(8'h05, 8, ack);
      m.send(8'h1A, 3, ack);
      m.stop();
      repeat (20) @(posedge sys_clk);
      check("pending", 8'(exp_q.size()), 8'h00);
      $display("stream and abort done");
      give_verdict();
   end
endmodule
`default_nettype wire
